// *** design/rcdc_regs.sv ***
`timescale 1ns/1ps
module rcdc_regs #(
  parameter int RETRY_TIMEOUT_CYCLES = rcdc_pkg::RCDC_RETRY_LIMIT_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input rcdc_pkg::rcdc_bus_req_s bus_req,
  output logic [7:0] bus_rdata,
  input wire logic host_retry_issued,
  input wire logic host_master_returned,
  input wire logic card_bus_retry_issued,
  input wire logic card_bus_master_returned,
  input rcdc_pkg::rcdc_card_in_s card_pins,
  input wire logic ring_terminal_select,
  input wire logic [3:0] multipurpose_terminal_2_cfg,
  output logic power_event_terminal,
  output logic ring_indicate_output,
  output logic multipurpose_terminal_2,
  output logic audio_pwm_signal,
  output logic speaker_output_terminal,
  output logic speaker_output_oe,
  output logic video_port_oe,
  output logic host_retry_counter_en,
  output logic card_bus_retry_counter_en,
  output logic host_retry_expired,
  output logic card_bus_retry_expired,
  output logic video_port_hiz_enable,
  output logic card_function_irq_flag,
  output logic low_voltage_capable_force,
  output logic diag_storage_bit,
  output logic interrogation_short,
  output rcdc_pkg::rcdc_irq_mode_e irq_signalling_select
);
  import rcdc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // address decode, shared by the write and read paths
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction : hit

  rcdc_state_s st_q;
  rcdc_state_s st_d;
  rcdc_card_in_s card_sync;
  logic [RCDC_NUM_TIMERS-1:0] tmr_en;
  logic [RCDC_NUM_TIMERS-1:0] tmr_retry;
  logic [RCDC_NUM_TIMERS-1:0] tmr_return;
  logic [RCDC_NUM_TIMERS-1:0] tmr_expired;
  logic wr_retry;
  logic wr_card;
  logic wr_device;
  logic audio_now;

  ////////////////////////////////////////////////////////////////////////////
  // card-side pins arrive from outside the clock domain
  rcdc_sync2 #(
    .W($bits(rcdc_card_in_s))
  ) u_card_sync (
    .clock(clock),
    .rst(rst),
    .async_in(card_pins),
    .sync_out(card_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // one retry timeout counter per target side
  assign tmr_en[RCDC_TMR_HOST] = st_q.retry[RCDC_RT_HOST_EN];
  assign tmr_en[RCDC_TMR_CARD] = st_q.retry[RCDC_RT_CARD_EN];
  assign tmr_retry = {card_bus_retry_issued, host_retry_issued};
  assign tmr_return = {card_bus_master_returned, host_master_returned};

  genvar gi;
  generate
    for (gi = 0; gi < RCDC_NUM_TIMERS; gi++)
    begin : g_timer
      rcdc_retry_timer #(
        .LIMIT(RETRY_TIMEOUT_CYCLES)
      ) u_timer (
        .clock(clock),
        .rst(rst),
        .enable(tmr_en[gi]),
        .retry_ev(tmr_retry[gi]),
        .return_ev(tmr_return[gi]),
        .expired(tmr_expired[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // write decode
  assign wr_retry = bus_req.wr && hit(bus_req.addr, RCDC_ADDR_RETRY);
  assign wr_card = bus_req.wr && hit(bus_req.addr, RCDC_ADDR_CARD);
  assign wr_device = bus_req.wr && hit(bus_req.addr, RCDC_ADDR_DEVICE);
  assign audio_now = st_q.card[RCDC_CC_AUDIO_EN] && card_sync.audio;

  // next state: writes first, hardware sets last so a set beats a clear
  always_comb
  begin
    st_d = st_q;

    // retry status: only rw bits store; reserved bits never get set
    if (wr_retry)
    begin
      st_d.retry = (st_q.retry & ~(RCDC_RETRY_RW_MASK | (bus_req.wdata & RCDC_RETRY_W1C_MASK)))
        | (bus_req.wdata & RCDC_RETRY_RW_MASK);
    end
    if (tmr_expired[RCDC_TMR_HOST])
      st_d.retry[RCDC_RT_HOST_EXP] = 1'b1;
    if (tmr_expired[RCDC_TMR_CARD])
      st_d.retry[RCDC_RT_CARD_EXP] = 1'b1;

    // card control: bit 5 is plain storage, bits 4:3 stay zero
    if (wr_card)
    begin
      st_d.card = (st_q.card & ~(RCDC_CARD_RW_MASK | (bus_req.wdata & RCDC_CARD_W1C_MASK)))
        | (bus_req.wdata & RCDC_CARD_RW_MASK);
    end
    // level interrupt: flag cannot be cleared while the card still asserts
    if (card_sync.irq)
      st_d.card[RCDC_CC_IRQ_FLAG] = 1'b1;

    // device control: bits 7 and 4 are masked off on every write
    if (wr_device)
      st_d.device = bus_req.wdata & RCDC_DEVICE_RW_MASK;

    // read data stand for exactly the cycle after the strobe
    st_d.rdata = '0;
    if (bus_req.rd)
    begin
      if (hit(bus_req.addr, RCDC_ADDR_RETRY))
        st_d.rdata = st_q.retry;
      else if (hit(bus_req.addr, RCDC_ADDR_CARD))
        st_d.rdata = st_q.card;
      else if (hit(bus_req.addr, RCDC_ADDR_DEVICE))
        st_d.rdata = st_q.device;
      else
        st_d.rdata = '0;
    end

    // pin outputs, registered so they never glitch on the terminals
    st_d.pins.ring_pme_out = st_q.card[RCDC_CC_RING_EN] && card_sync.ring
      && !ring_terminal_select;
    st_d.pins.ring_route_out = st_q.card[RCDC_CC_RING_EN] && card_sync.ring;
    st_d.pins.audio_pwm = audio_now;
    st_d.pins.multipurpose_terminal_2_out = (multipurpose_terminal_2_cfg == RCDC_MFUNC_AUDIO_PWM)
      && audio_now;
    st_d.pins.speaker_out = st_q.card[RCDC_CC_CARD_SPEAKER_SIGNAL_EN] && card_sync.speaker;
    st_d.pins.speaker_oe = st_q.card[RCDC_CC_CARD_SPEAKER_SIGNAL_EN];
    st_d.pins.video_oe = !st_q.card[RCDC_CC_VIDEO_HIZ];
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_q.retry <= RCDC_RETRY_RESET;
      st_q.card <= RCDC_CARD_RESET;
      st_q.device <= RCDC_DEVICE_RESET;
      st_q.rdata <= '0;
      st_q.pins <= '0;
    end
    else
      st_q <= st_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops
  assign bus_rdata = st_q.rdata;
  assign power_event_terminal = st_q.pins.ring_pme_out;
  assign ring_indicate_output = st_q.pins.ring_route_out;
  assign multipurpose_terminal_2 = st_q.pins.multipurpose_terminal_2_out;
  assign audio_pwm_signal = st_q.pins.audio_pwm;
  assign speaker_output_terminal = st_q.pins.speaker_out;
  assign speaker_output_oe = st_q.pins.speaker_oe;
  assign video_port_oe = st_q.pins.video_oe;
  assign host_retry_counter_en = st_q.retry[RCDC_RT_HOST_EN];
  assign card_bus_retry_counter_en = st_q.retry[RCDC_RT_CARD_EN];
  assign host_retry_expired = st_q.retry[RCDC_RT_HOST_EXP];
  assign card_bus_retry_expired = st_q.retry[RCDC_RT_CARD_EXP];
  assign video_port_hiz_enable = st_q.card[RCDC_CC_VIDEO_HIZ];
  assign card_function_irq_flag = st_q.card[RCDC_CC_IRQ_FLAG];
  assign low_voltage_capable_force = st_q.device[RCDC_DC_LV_FORCE];
  assign diag_storage_bit = st_q.device[RCDC_DC_DIAG];
  assign interrogation_short = st_q.device[RCDC_DC_TEST];
  assign irq_signalling_select =
    rcdc_irq_mode_e'(st_q.device[RCDC_DC_MODE_HI:RCDC_DC_MODE_LO]);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_host_flag_set: assert property (tmr_expired[RCDC_TMR_HOST] |=> host_retry_expired)
    else $error("host expiry did not set flag");

  a_host_flag_clear: assert property (wr_retry && bus_req.wdata[RCDC_RT_HOST_EXP]
    && !tmr_expired[RCDC_TMR_HOST] |=> !host_retry_expired)
    else $error("host flag not cleared by one");

  a_host_flag_hold: assert property (host_retry_expired && !(wr_retry
    && bus_req.wdata[RCDC_RT_HOST_EXP]) |=> host_retry_expired)
    else $error("host flag lost without clear");

  a_card_flag_clear: assert property (wr_retry && bus_req.wdata[RCDC_RT_CARD_EXP]
    && !tmr_expired[RCDC_TMR_CARD] |=> !card_bus_retry_expired)
    else $error("card flag not cleared by one");

  a_card_set_wins: assert property (tmr_expired[RCDC_TMR_CARD] && wr_retry
    |=> card_bus_retry_expired)
    else $error("card flag clear beat set");

  a_retry_reserved_zero: assert property (bus_req.rd && hit(bus_req.addr, RCDC_ADDR_RETRY)
    |=> (bus_rdata & ~(RCDC_RETRY_RW_MASK | RCDC_RETRY_W1C_MASK)) == 8'h00)
    else $error("retry reserved bits nonzero");

  a_disabled_no_expiry: assert property (!host_retry_counter_en
    |=> !tmr_expired[RCDC_TMR_HOST])
    else $error("disabled host counter expired");

  a_ring_gated: assert property (!st_q.card[RCDC_CC_RING_EN]
    |=> !power_event_terminal && !ring_indicate_output)
    else $error("ring output while disabled");

  a_video_float: assert property (wr_card && bus_req.wdata[RCDC_CC_VIDEO_HIZ]
    |=> ##1 !video_port_oe)
    else $error("video port still driven");

  a_speaker_gate: assert property (speaker_output_terminal |-> speaker_output_oe
    && $past(st_q.card[RCDC_CC_CARD_SPEAKER_SIGNAL_EN]))
    else $error("speaker data while disabled");

  a_irq_sticky: assert property (card_function_irq_flag && !wr_card
    |=> card_function_irq_flag)
    else $error("interrupt flag dropped");

  a_card_reserved: assert property (bus_req.rd && hit(bus_req.addr, RCDC_ADDR_CARD)
    |=> (bus_rdata & ~(RCDC_CARD_RW_MASK | RCDC_CARD_W1C_MASK)) == 8'h00)
    else $error("card reserved bits nonzero");

  a_device_write: assert property (wr_device |=> st_q.device
    == ($past(bus_req.wdata) & RCDC_DEVICE_RW_MASK))
    else $error("device write wrong");

  a_mode_follows: assert property (wr_device |=> irq_signalling_select
    == rcdc_irq_mode_e'($past(bus_req.wdata[RCDC_DC_MODE_HI:RCDC_DC_MODE_LO])))
    else $error("interrupt mode not updated");

  // both directions, so a terminal stuck low or a wrong code decode fires too
  a_mfunc_audio: assert property (multipurpose_terminal_2 == (audio_pwm_signal
    && $past(multipurpose_terminal_2_cfg == RCDC_MFUNC_AUDIO_PWM)))
    else $error("terminal 2 pwm mismatch");

  a_unmapped_zero: assert property (bus_req.rd && !hit(bus_req.addr, RCDC_ADDR_RETRY)
    && !hit(bus_req.addr, RCDC_ADDR_CARD) && !hit(bus_req.addr, RCDC_ADDR_DEVICE)
    |=> bus_rdata == 8'h00)
    else $error("unmapped read nonzero");

  a_card_flag_set: assert property (tmr_expired[RCDC_TMR_CARD] |=> card_bus_retry_expired)
    else $error("card expiry did not set flag");

  a_card_flag_hold: assert property (card_bus_retry_expired && !(wr_retry
    && bus_req.wdata[RCDC_RT_CARD_EXP]) |=> card_bus_retry_expired)
    else $error("card flag lost without clear");

  a_retry_enables: assert property (wr_retry |=> {host_retry_counter_en,
    card_bus_retry_counter_en} == $past(bus_req.wdata[RCDC_RT_HOST_EN:RCDC_RT_CARD_EN]))
    else $error("counter enables not stored");

  a_card_disabled_quiet: assert property (!card_bus_retry_counter_en
    |=> !tmr_expired[RCDC_TMR_CARD])
    else $error("disabled card counter expired");

  a_audio_gate: assert property (audio_pwm_signal == ($past(st_q.card[RCDC_CC_AUDIO_EN])
    && $past(card_sync.audio)))
    else $error("audio pwm routing wrong");

  a_irq_capture: assert property (card_sync.irq |=> card_function_irq_flag)
    else $error("interrupt level not captured");

  a_device_reserved: assert property (bus_req.rd && hit(bus_req.addr, RCDC_ADDR_DEVICE)
    |=> (bus_rdata & ~RCDC_DEVICE_RW_MASK) == 8'h00)
    else $error("device reserved bits nonzero");

  a_video_hiz: assert property (video_port_hiz_enable |=> !video_port_oe)
    else $error("video port driven while floating");

  a_ring_select: assert property (power_event_terminal |-> !$past(ring_terminal_select))
    else $error("ring on power terminal while deselected");

  // read data must not linger, or software could see a stale byte
  a_rdata_idle: assert property (!bus_req.rd |=> bus_rdata == 8'h00)
    else $error("read data outside read slot");

  c_host_expiry: cover property (tmr_expired[RCDC_TMR_HOST]);
  c_set_beats_clear: cover property (tmr_expired[RCDC_TMR_CARD] && wr_retry
    && bus_req.wdata[RCDC_RT_CARD_EXP]);
  c_card_expiry_clear: cover property (card_bus_retry_expired ##1 wr_retry
    ##1 !card_bus_retry_expired);
  c_irq_flag_set: cover property (!card_function_irq_flag ##1 card_function_irq_flag);
  c_audio_on_terminal: cover property (multipurpose_terminal_2);

endmodule : rcdc_regs

// *** design/rcdc_pkg.sv ***
// What this block does
// - unreturned retry after limit sets expiry flag
// - retry bit 7 enables host-side counter, resets 1
// - retry bit 6 enables card-side counter, resets 1
// - retry bit 3 card expiry, write one clears
// - retry bit 1 host expiry, one clears
// - retry bits 5:4, 2, 0 read zero
// - card bit 7 gates ring-indicate output routing
// - card bit 6 floats video port terminals
// - card bit 2 routes card audio to pwm
// - card bit 1 passes speaker signal through
// - card bit 0 sticky interrupt flag, one clears
// - card bit 5 plain storage, 4:3 zero
// - device bit 6 forces low-voltage capability, resets 1
// - device bits 2:1 select interrupt signalling mode
// - device bit 3 shortens interrogation counter
// - device bits 7 and 4 read zero
// - terminal code 1000 outputs audio pwm signal
package rcdc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [7:0] RCDC_ADDR_RETRY = 8'h90;
  localparam logic [7:0] RCDC_ADDR_CARD = 8'h91;
  localparam logic [7:0] RCDC_ADDR_DEVICE = 8'h92;

  localparam logic [7:0] RCDC_RETRY_RESET = 8'hc0;
  localparam logic [7:0] RCDC_CARD_RESET = 8'h00;
  localparam logic [7:0] RCDC_DEVICE_RESET = 8'h66;

  // plain read/write bits and write-one-to-clear bits per register
  localparam logic [7:0] RCDC_RETRY_RW_MASK = 8'hc0;
  localparam logic [7:0] RCDC_RETRY_W1C_MASK = 8'h0a;
  localparam logic [7:0] RCDC_CARD_RW_MASK = 8'he6;
  localparam logic [7:0] RCDC_CARD_W1C_MASK = 8'h01;
  localparam logic [7:0] RCDC_DEVICE_RW_MASK = 8'h6f;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int RCDC_RT_HOST_EN = 7;
  localparam int RCDC_RT_CARD_EN = 6;
  localparam int RCDC_RT_CARD_EXP = 3;
  localparam int RCDC_RT_HOST_EXP = 1;

  localparam int RCDC_CC_RING_EN = 7;
  localparam int RCDC_CC_VIDEO_HIZ = 6;
  localparam int RCDC_CC_AUDIO_EN = 2;
  localparam int RCDC_CC_CARD_SPEAKER_SIGNAL_EN = 1;
  localparam int RCDC_CC_IRQ_FLAG = 0;

  localparam int RCDC_DC_LV_FORCE = 6;
  localparam int RCDC_DC_DIAG = 5;
  localparam int RCDC_DC_TEST = 3;
  localparam int RCDC_DC_MODE_HI = 2;
  localparam int RCDC_DC_MODE_LO = 1;

  ////////////////////////////////////////////////////////////////////////////
  // timing and encodings
  localparam int RCDC_RETRY_LIMIT_EXP = 15;
  localparam int RCDC_RETRY_LIMIT_CYCLES = 1 << RCDC_RETRY_LIMIT_EXP;
  localparam logic [3:0] RCDC_MFUNC_AUDIO_PWM = 4'h8;
  localparam int RCDC_NUM_TIMERS = 2;
  localparam int RCDC_TMR_HOST = 0;
  localparam int RCDC_TMR_CARD = 1;

  typedef enum logic [1:0]
  {
    RCDC_IRQ_PAR_PCI = 2'h0,
    RCDC_IRQ_PAR_IRQ_PCI = 2'h1,
    RCDC_IRQ_SER_IRQ_PAR_PCI = 2'h2,
    RCDC_IRQ_SER_ALL = 2'h3
  } rcdc_irq_mode_e;

  typedef enum logic
  {
    RCDC_TMR_IDLE = 1'b0,
    RCDC_TMR_WAIT = 1'b1
  } rcdc_tmr_mode_e;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed
  {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rcdc_bus_req_s;

  typedef struct packed
  {
    logic irq;
    logic audio;
    logic speaker;
    logic ring;
  } rcdc_card_in_s;

  typedef struct packed
  {
    logic ring_pme_out;
    logic ring_route_out;
    logic multipurpose_terminal_2_out;
    logic audio_pwm;
    logic speaker_out;
    logic speaker_oe;
    logic video_oe;
  } rcdc_pins_out_s;

  typedef struct packed
  {
    logic [7:0] retry;
    logic [7:0] card;
    logic [7:0] device;
    logic [7:0] rdata;
    rcdc_pins_out_s pins;
  } rcdc_state_s;

endpackage : rcdc_pkg

// *** design/rcdc_sync2.sv ***
`timescale 1ns/1ps
module rcdc_sync2 #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  import rcdc_pkg::*;

  typedef struct packed
  {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } rcdc_sync_state_s;

  rcdc_sync_state_s st_q;
  rcdc_sync_state_s st_d;

  // stage1 feeds stage2 only, so metastability never reaches logic
  always_comb
  begin
    st_d = st_q;
    st_d.stage1 = async_in;
    st_d.stage2 = st_q.stage1;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign sync_out = st_q.stage2;

endmodule : rcdc_sync2

// *** design/rcdc_retry_timer.sv ***
`timescale 1ns/1ps
module rcdc_retry_timer #(
  parameter int LIMIT = rcdc_pkg::RCDC_RETRY_LIMIT_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  input wire logic retry_ev,
  input wire logic return_ev,
  output logic expired
);
  import rcdc_pkg::*;

  localparam int CNT_W = $clog2(LIMIT) + 1;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(LIMIT - 1);

  typedef struct packed
  {
    rcdc_tmr_mode_e mode;
    logic [CNT_W-1:0] count;
    logic expired;
  } rcdc_tmr_state_s;

  rcdc_tmr_state_s st_q;
  rcdc_tmr_state_s st_d;

  // a return that is retried again in the same cycle restarts the wait
  always_comb
  begin
    st_d = st_q;
    st_d.expired = 1'b0;
    if (!enable)
    begin
      st_d.mode = RCDC_TMR_IDLE;
      st_d.count = '0;
    end
    else
    begin
      case (st_q.mode)
        RCDC_TMR_IDLE:
        begin
          if (retry_ev)
          begin
            st_d.mode = RCDC_TMR_WAIT;
            st_d.count = '0;
          end
        end
        RCDC_TMR_WAIT:
        begin
          if (return_ev)
          begin
            st_d.mode = retry_ev ? RCDC_TMR_WAIT : RCDC_TMR_IDLE;
            st_d.count = '0;
          end
          else if (st_q.count == LAST)
          begin
            st_d.expired = 1'b1;
            st_d.mode = RCDC_TMR_IDLE;
            st_d.count = '0;
          end
          else
            st_d.count = CNT_W'(st_q.count + 1'b1);
        end
        default:
        begin
          st_d.mode = RCDC_TMR_IDLE;
          st_d.count = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign expired = st_q.expired;

  a_expiry_after_limit: assert property (@(posedge clock) disable iff (rst)
    expired |-> $past(st_q.count) == LAST && $past(enable))
    else $error("expiry without full wait");

endmodule : rcdc_retry_timer

// *** verification/rcdc_master_model.sv ***
`timescale 1ns/1ps
module rcdc_master_model (
  input wire logic clock,
  output logic host_retry,
  output logic host_back,
  output logic card_retry,
  output logic card_back
);
  ////////////////////////////////////////////////////////////////////////////
  // masters start quiet
  initial
  begin
    host_retry = 1'b0;
    host_back = 1'b0;
    card_retry = 1'b0;
    card_back = 1'b0;
  end

  // one retried master; a negative gap means it never comes back,
  // which is the only misbehaviour the bench ever asks for
  task automatic retry_once(input bit card, input int gap);
    begin
      @(posedge clock);
      if (card)
        card_retry <= 1'b1;
      else
        host_retry <= 1'b1;
      @(posedge clock);
      card_retry <= 1'b0;
      host_retry <= 1'b0;
      if (gap >= 0)
      begin
        repeat (gap) @(posedge clock);
        if (card)
          card_back <= 1'b1;
        else
          host_back <= 1'b1;
        @(posedge clock);
        card_back <= 1'b0;
        host_back <= 1'b0;
      end
    end
  endtask : retry_once
endmodule : rcdc_master_model

// *** verification/tb.sv ***
`timescale 1ns/1ps
module tb;
  import rcdc_pkg::*;
  localparam int LIM = 8;
  logic clock;
  logic rst;
  rcdc_bus_req_s bus_req;
  logic [7:0] bus_rdata;
  logic h_ret, h_back, c_ret, c_back;
  rcdc_card_in_s card_pins;
  logic sel;
  logic [3:0] cfg;
  logic pe, ri, mf, au, sp, soe, voe, h_en, c_en, h_exp, c_exp, hiz, irqf, lv, diag, short_q;
  rcdc_irq_mode_e mode;
  int checks = 0;
  int miscompares = 0;

  ////////////////////////////////////////////////////////////////////////////
  rcdc_regs #(.RETRY_TIMEOUT_CYCLES(LIM)) rcdc_regs_i (
    .clock(clock), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .host_retry_issued(h_ret), .host_master_returned(h_back),
    .card_bus_retry_issued(c_ret), .card_bus_master_returned(c_back),
    .card_pins(card_pins), .ring_terminal_select(sel), .multipurpose_terminal_2_cfg(cfg),
    .power_event_terminal(pe), .ring_indicate_output(ri), .multipurpose_terminal_2(mf),
    .audio_pwm_signal(au), .speaker_output_terminal(sp), .speaker_output_oe(soe),
    .video_port_oe(voe), .host_retry_counter_en(h_en), .card_bus_retry_counter_en(c_en),
    .host_retry_expired(h_exp), .card_bus_retry_expired(c_exp),
    .video_port_hiz_enable(hiz), .card_function_irq_flag(irqf),
    .low_voltage_capable_force(lv), .diag_storage_bit(diag),
    .interrogation_short(short_q), .irq_signalling_select(mode));
  rcdc_master_model rcdc_master_model_i (.clock(clock), .host_retry(h_ret),
    .host_back(h_back), .card_retry(c_ret), .card_back(c_back));

  ////////////////////////////////////////////////////////////////////////////
  // shared checking and bus cycles
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    bus_req <= '0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    bus_req <= '0;
    #1;
    chk(what, bus_rdata, exp);
  endtask : rchk

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    rchk("retry", RCDC_ADDR_RETRY, 8'hc0);
    rchk("card", RCDC_ADDR_CARD, 8'h00);
    rchk("device", RCDC_ADDR_DEVICE, 8'h66);
    chk("dev_bits", {5'h00, lv, diag, short_q}, 8'h06);
    chk("mode", 8'(mode), 8'h03);
    $display("done reset values");
  endtask : t_reset

  task automatic t_masks;
    wr(RCDC_ADDR_RETRY, 8'hf5);
    rchk("retry_ro", RCDC_ADDR_RETRY, 8'hc0);
    wr(RCDC_ADDR_CARD, 8'hfe);
    rchk("card_ro", RCDC_ADDR_CARD, 8'he6);
    wr(RCDC_ADDR_DEVICE, 8'hfe);
    rchk("dev_ro", RCDC_ADDR_DEVICE, 8'h6e);
    chk("dev_bits", {5'h00, lv, diag, short_q}, 8'h07);
    for (int m = 0; m < 4; m++)
    begin
      wr(RCDC_ADDR_DEVICE, 8'(m << 1));
      settle(1);
      chk("mode", 8'(mode), 8'(m));
    end
    chk("dev_bits", {5'h00, lv, diag, short_q}, 8'h00);
    wr(8'h93, 8'hff);
    rchk("unmapped", 8'h93, 8'h00);
    wr(RCDC_ADDR_CARD, 8'h00);
    wr(RCDC_ADDR_DEVICE, 8'h66);
    $display("done masks");
  endtask : t_masks

  // flag must rise exactly LIM+1 edges after the retry edge
  task automatic t_expiry(input bit card);
    rcdc_master_model_i.retry_once(card, -1);
    settle(LIM);
    chk("early", {7'h00, card ? c_exp : h_exp}, 8'h00);
    settle(1);
    chk("flag", {7'h00, card ? c_exp : h_exp}, 8'h01);
  endtask : t_expiry

  task automatic t_flags;
    t_expiry(1'b0);
    t_expiry(1'b1);
    rchk("both", RCDC_ADDR_RETRY, 8'hca);
    wr(RCDC_ADDR_RETRY, 8'hc0);
    rchk("keep", RCDC_ADDR_RETRY, 8'hca);
    wr(RCDC_ADDR_RETRY, 8'hc2);
    rchk("host_clr", RCDC_ADDR_RETRY, 8'hc8);
    wr(RCDC_ADDR_RETRY, 8'hc8);
    rchk("card_clr", RCDC_ADDR_RETRY, 8'hc0);
    // clear lands on the very edge the expiry pulse is taken: set must win
    rcdc_master_model_i.retry_once(1'b1, -1);
    settle(LIM - 1);
    wr(RCDC_ADDR_RETRY, 8'hc8);
    settle(1);
    chk("set_wins", {7'h00, c_exp}, 8'h01);
    wr(RCDC_ADDR_RETRY, 8'hc8);
    $display("done expiry flags");
  endtask : t_flags

  task automatic t_no_expiry;
    rcdc_master_model_i.retry_once(1'b0, LIM / 2);
    rcdc_master_model_i.retry_once(1'b1, LIM / 2);
    settle(LIM + 4);
    rchk("returned", RCDC_ADDR_RETRY, 8'hc0);
    wr(RCDC_ADDR_RETRY, 8'h00);
    settle(1);
    chk("en", {6'h00, h_en, c_en}, 8'h00);
    rcdc_master_model_i.retry_once(1'b0, -1);
    rcdc_master_model_i.retry_once(1'b1, -1);
    settle(LIM + 4);
    rchk("disabled", RCDC_ADDR_RETRY, 8'h00);
    wr(RCDC_ADDR_RETRY, 8'hc0);
    settle(1);
    chk("en", {6'h00, h_en, c_en}, 8'h03);
    $display("done returns and disable");
  endtask : t_no_expiry

  task automatic t_irq;
    card_pins.irq <= 1'b1;
    settle(4);
    rchk("irq_set", RCDC_ADDR_CARD, 8'h01);
    wr(RCDC_ADDR_CARD, 8'h01);
    rchk("irq_held", RCDC_ADDR_CARD, 8'h01);
    card_pins.irq <= 1'b0;
    settle(4);
    wr(RCDC_ADDR_CARD, 8'h00);
    settle(1);
    chk("irq_stick", {7'h00, irqf}, 8'h01);
    wr(RCDC_ADDR_CARD, 8'h01);
    rchk("irq_clr", RCDC_ADDR_CARD, 8'h00);
    $display("done interrupt flag");
  endtask : t_irq

  // order: pe ri mf au sp soe voe hiz
  task automatic t_routing;
    card_pins <= '{irq: 1'b0, audio: 1'b1, speaker: 1'b1, ring: 1'b1};
    cfg <= RCDC_MFUNC_AUDIO_PWM;
    settle(4);
    chk("gated", {pe, ri, mf, au, sp, soe, voe, hiz}, 8'h02);
    wr(RCDC_ADDR_CARD, 8'hc6);
    settle(4);
    chk("routed", {pe, ri, mf, au, sp, soe, voe, hiz}, 8'hfd);
    sel <= 1'b1;
    cfg <= 4'h0;
    settle(4);
    chk("alt", {pe, ri, mf, au, sp, soe, voe, hiz}, 8'h5d);
    wr(RCDC_ADDR_CARD, 8'h00);
    settle(4);
    chk("off", {pe, ri, mf, au, sp, soe, voe, hiz}, 8'h02);
    $display("done routing");
  endtask : t_routing

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  // free-running clock
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // whole run is under two hundred cycles; this cuts a hang short
  initial
  begin
    #50us;
    miscompares++;
    print_verdict();
  end

  // main sequence
  initial
  begin
    rst = 1'b1;
    bus_req = '0;
    card_pins = '0;
    sel = 1'b0;
    cfg = 4'h0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_masks();
    t_flags();
    t_no_expiry();
    t_irq();
    t_routing();
    print_verdict();
  end
endmodule : tb
